// *** acsr_map.svh ***
// Purpose: offsets, field positions, masks and reset values of the converter status/control block
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes:   definitions only
`ifndef ACSR_MAP_SVH
`define ACSR_MAP_SVH

`define ACSR_ADDR_W            12

`define ACSR_OFS_STATUS        12'h000
`define ACSR_OFS_CTRL_ONE      12'h004
`define ACSR_OFS_CTRL_TWO      12'h008

`define ACSR_STATUS_RESET      5'h00
`define ACSR_CTRL_ONE_RESET    32'h0000_0000
`define ACSR_CTRL_TWO_RESET    32'h0000_0000

// writable bits; everything else stays at its reset value of zero
`define ACSR_CTRL_ONE_MASK     32'h00c0_ffff
`define ACSR_CTRL_TWO_MASK     32'h00fe_f90f

`define ACSR_FLAG_WATCHDOG     0
`define ACSR_FLAG_CONV_END     1
`define ACSR_FLAG_INJ_END      2
`define ACSR_FLAG_INJ_START    3
`define ACSR_FLAG_REG_START    4
`define ACSR_FLAG_COUNT        5

`define ACSR_C1_WD_REGULAR     23
`define ACSR_C1_WD_INJECTED    22
`define ACSR_C1_BURST_MSB      15
`define ACSR_C1_BURST_LSB      13
`define ACSR_C1_INJ_BURST      12
`define ACSR_C1_REG_BURST      11
`define ACSR_C1_AUTO_INJ       10
`define ACSR_C1_WD_SINGLE      9
`define ACSR_C1_SCAN           8
`define ACSR_C1_INJ_END_IE     7
`define ACSR_C1_WD_IE          6
`define ACSR_C1_CONV_END_IE    5
`define ACSR_C1_WD_CH_MSB      4
`define ACSR_C1_WD_CH_LSB      0
`define ACSR_WD_CHANNEL_MAX    5'h11

`define ACSR_RESP_OKAY         2'h0
`define ACSR_RESP_SLVERR       2'h2

`endif

// *** acsr_pkg.sv ***
// Purpose: types shared by the converter status/control block
// Assumes: acsr_map.svh constants
// Notes:   state of each module is one packed struct
`include "acsr_map.svh"

package acsr_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_REGULAR,
		SEQ_INJECTED
	} acsr_seq_type;

	typedef struct packed {
		logic                     wr_en;
		logic [`ACSR_ADDR_W-1:0]  wr_addr;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     rd_en;
		logic [`ACSR_ADDR_W-1:0]  rd_addr;
	} acsr_reg_req_type;

	typedef struct packed {
		logic                     wr_hit;
		logic                     rd_hit;
		logic [31:0]              rdata;
	} acsr_reg_rsp_type;

	typedef struct packed {
		logic                     valid;
		logic                     injected;
		logic [4:0]               channel;
		logic [11:0]              result;
	} acsr_conv_done_type;

	typedef struct packed {
		logic                     aw_held;
		logic [`ACSR_ADDR_W-1:0]  aw_addr;
		logic                     w_held;
		logic [31:0]              w_data;
		logic [3:0]               w_strb;
		logic                     b_valid;
		logic [1:0]               b_resp;
		logic                     r_valid;
		logic [31:0]              r_data;
		logic [1:0]               r_resp;
	} acsr_port_state_type;

	typedef struct packed {
		logic [`ACSR_FLAG_COUNT-1:0] flags;
		logic [31:0]              ctrl_one;
		logic [31:0]              ctrl_two;
		acsr_seq_type             seq;
		logic [3:0]               reg_pos;
		logic [2:0]               burst_left;
		logic [1:0]               inj_pos;
		logic                     inj_pending;
		logic                     reg_resume;
		logic                     start;
		logic                     start_injected;
		logic [3:0]               start_slot;
	} acsr_core_state_type;

endpackage : acsr_pkg

// *** acsr_axil_port.sv ***
// Purpose: AXI4-Lite slave front end, turns bus transfers into one-cycle register strobes
// Assumes: one write and one read outstanding at most
// Notes:   address and data may arrive in either order; write strobe fires once both are held
`timescale 1ns/1ps

module acsr_axil_port
	import acsr_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [`ACSR_ADDR_W-1:0] awaddr,
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	input  wire logic                    wvalid,
	output logic                         wready,
	output logic [1:0]                   bresp,
	output logic                         bvalid,
	input  wire logic                    bready,
	input  wire logic [`ACSR_ADDR_W-1:0] araddr,
	input  wire logic                    arvalid,
	output logic                         arready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp,
	output logic                         rvalid,
	input  wire logic                    rready,
	output acsr_reg_req_type             req,
	input  wire acsr_reg_rsp_type        rsp
);

	acsr_port_state_type cur;
	acsr_port_state_type next_cur;

	// no new address or data is taken while a response waits, so writes never overlap
	assign awready = !cur.aw_held && !cur.b_valid;
	assign wready  = !cur.w_held && !cur.b_valid;
	assign arready = !cur.r_valid;
	assign bvalid  = cur.b_valid;
	assign bresp   = cur.b_resp;
	assign rvalid  = cur.r_valid;
	assign rdata   = cur.r_data;
	assign rresp   = cur.r_resp;

	always_comb begin
		next_cur = cur;
		req.wr_en   = cur.aw_held && cur.w_held && !cur.b_valid;
		req.wr_addr = cur.aw_addr;
		req.wdata   = cur.w_data;
		req.wstrb   = cur.w_strb;
		req.rd_en   = arvalid && !cur.r_valid;
		req.rd_addr = araddr;
		if (awvalid && awready) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = wdata;
			next_cur.w_strb = wstrb;
		end
		if (req.wr_en) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held  = 1'b0;
			next_cur.b_valid = 1'b1;
			next_cur.b_resp  = rsp.wr_hit ? `ACSR_RESP_OKAY : `ACSR_RESP_SLVERR;
		end
		if (cur.b_valid && bready) begin
			next_cur.b_valid = 1'b0;
		end
		if (cur.r_valid && rready) begin
			next_cur.r_valid = 1'b0;
		end
		if (req.rd_en) begin
			next_cur.r_valid = 1'b1;
			next_cur.r_data  = rsp.rdata;
			next_cur.r_resp  = rsp.rd_hit ? `ACSR_RESP_OKAY : `ACSR_RESP_SLVERR;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

endmodule : acsr_axil_port

// *** acsr_regs.sv ***
// Purpose: status flags, first and second control registers and group sequencing of a converter
// Assumes: converter core, triggers and result-read strobe run on REF_CLK (40 MHz)
// Notes:   sequence lists and thresholds live outside; this block picks slots and raises flags
`timescale 1ns/1ps

module acsr_regs
	import acsr_pkg::*;
(
	input  wire logic                    REF_CLK,
	input  wire logic                    SYS_RST,
	input  wire logic [`ACSR_ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                    S_AXI_AWVALID,
	output logic                         S_AXI_AWREADY,
	input  wire logic [31:0]             S_AXI_WDATA,
	input  wire logic [3:0]              S_AXI_WSTRB,
	input  wire logic                    S_AXI_WVALID,
	output logic                         S_AXI_WREADY,
	output logic [1:0]                   S_AXI_BRESP,
	output logic                         S_AXI_BVALID,
	input  wire logic                    S_AXI_BREADY,
	input  wire logic [`ACSR_ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                    S_AXI_ARVALID,
	output logic                         S_AXI_ARREADY,
	output logic [31:0]                  S_AXI_RDATA,
	output logic [1:0]                   S_AXI_RRESP,
	output logic                         S_AXI_RVALID,
	input  wire logic                    S_AXI_RREADY,
	input  wire logic                    REG_TRIGGER,
	input  wire logic                    INJ_TRIGGER,
	input  wire logic                    RESULT_READ,
	input  wire acsr_conv_done_type      CONV_DONE,
	input  wire logic [3:0]              REG_SEQ_LAST,
	input  wire logic [1:0]              INJ_SEQ_LAST,
	input  wire logic [11:0]             LOW_THRESHOLD,
	input  wire logic [11:0]             HIGH_THRESHOLD,
	output logic                         CONV_START,
	output logic                         CONV_INJECTED,
	output logic [3:0]                   CONV_SLOT,
	output logic                         CONV_BUSY,
	output logic [31:0]                  CONTROL_TWO,
	output logic                         CONV_IRQ
);

	acsr_reg_req_type                req;
	acsr_reg_rsp_type                rsp;
	acsr_core_state_type             cur;
	acsr_core_state_type             next_cur;
	logic [`ACSR_FLAG_COUNT-1:0]     flag_set;
	logic [`ACSR_FLAG_COUNT-1:0]     flag_clr;
	logic                            reg_walk;
	logic                            inj_walk;
	logic                            reg_last;
	logic                            inj_last;
	logic                            burst_end;
	logic                            group_done;
	logic                            wd_scope;
	logic                            wd_channel_ok;

	acsr_axil_port u_port (
		.clk     (REF_CLK),
		.rst     (SYS_RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.req     (req),
		.rsp     (rsp)
	);

	// byte lanes are honoured even though software is expected to write whole words
	function automatic logic [31:0] merge_word(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0]  strb,
		input logic [31:0] mask
	);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
		return (old_word & ~lanes) | (new_word & lanes);
	endfunction : merge_word

	function automatic logic ctl(input logic [31:0] word, input int pos);
		return word[pos];
	endfunction : ctl

	// issues a one-cycle start to the converter core and waits for its done
	function automatic acsr_core_state_type launch(
		input acsr_core_state_type s,
		input logic                injected,
		input logic [3:0]          slot
	);
		acsr_core_state_type r;
		r = s;
		r.start          = 1'b1;
		r.start_injected = injected;
		r.start_slot     = slot;
		r.seq            = injected ? SEQ_INJECTED : SEQ_REGULAR;
		return r;
	endfunction : launch

	assign CONV_START    = cur.start;
	assign CONV_INJECTED = cur.start_injected;
	assign CONV_SLOT     = cur.start_slot;
	assign CONV_BUSY     = (cur.seq != SEQ_IDLE);
	assign CONTROL_TWO   = cur.ctrl_two;

	assign CONV_IRQ =
		(cur.flags[`ACSR_FLAG_INJ_END] && ctl(cur.ctrl_one, `ACSR_C1_INJ_END_IE)) ||
		(cur.flags[`ACSR_FLAG_WATCHDOG] && ctl(cur.ctrl_one, `ACSR_C1_WD_IE)) ||
		(cur.flags[`ACSR_FLAG_CONV_END] && ctl(cur.ctrl_one, `ACSR_C1_CONV_END_IE));

	// bursts and scan both walk the list; otherwise only the first slot is converted
	assign reg_walk  = ctl(cur.ctrl_one, `ACSR_C1_SCAN) || ctl(cur.ctrl_one, `ACSR_C1_REG_BURST);
	assign inj_walk  = ctl(cur.ctrl_one, `ACSR_C1_SCAN) || ctl(cur.ctrl_one, `ACSR_C1_INJ_BURST);
	assign reg_last  = !reg_walk || (cur.reg_pos == REG_SEQ_LAST);
	assign inj_last  = !inj_walk || (cur.inj_pos == INJ_SEQ_LAST);
	assign burst_end = ctl(cur.ctrl_one, `ACSR_C1_REG_BURST) && (cur.burst_left == 3'h0);

	assign wd_scope = CONV_DONE.injected ? ctl(cur.ctrl_one, `ACSR_C1_WD_INJECTED)
	                                     : ctl(cur.ctrl_one, `ACSR_C1_WD_REGULAR);
	// reserved channel codes never match a real channel, so they guard nothing
	assign wd_channel_ok = !ctl(cur.ctrl_one, `ACSR_C1_WD_SINGLE) ||
		((cur.ctrl_one[`ACSR_C1_WD_CH_MSB:`ACSR_C1_WD_CH_LSB] == CONV_DONE.channel) &&
		 (CONV_DONE.channel <= `ACSR_WD_CHANNEL_MAX));

	always_comb begin
		rsp.wr_hit = (req.wr_addr == `ACSR_OFS_STATUS) ||
		             (req.wr_addr == `ACSR_OFS_CTRL_ONE) ||
		             (req.wr_addr == `ACSR_OFS_CTRL_TWO);
		rsp.rd_hit = 1'b1;
		if (req.rd_addr == `ACSR_OFS_STATUS) begin
			rsp.rdata = {27'h0000000, cur.flags};
		end else if (req.rd_addr == `ACSR_OFS_CTRL_ONE) begin
			rsp.rdata = cur.ctrl_one;
		end else if (req.rd_addr == `ACSR_OFS_CTRL_TWO) begin
			rsp.rdata = cur.ctrl_two;
		end else begin
			rsp.rd_hit = 1'b0;
			rsp.rdata  = 32'h0000_0000;
		end
	end

	always_comb begin
		next_cur   = cur;
		next_cur.start = 1'b0;
		flag_set   = '0;
		flag_clr   = '0;
		group_done = 1'b0;

		if (req.wr_en) begin
			if (req.wr_addr == `ACSR_OFS_STATUS) begin
				// writing one leaves a flag alone, writing zero clears it
				if (req.wstrb[0]) begin
					flag_clr = ~req.wdata[`ACSR_FLAG_COUNT-1:0];
				end
			end else if (req.wr_addr == `ACSR_OFS_CTRL_ONE) begin
				next_cur.ctrl_one = merge_word(cur.ctrl_one, req.wdata, req.wstrb,
				                               `ACSR_CTRL_ONE_MASK);
			end else if (req.wr_addr == `ACSR_OFS_CTRL_TWO) begin
				next_cur.ctrl_two = merge_word(cur.ctrl_two, req.wdata, req.wstrb,
				                               `ACSR_CTRL_TWO_MASK);
			end
		end
		if (RESULT_READ) begin
			flag_clr[`ACSR_FLAG_CONV_END] = 1'b1;
		end

		if (CONV_DONE.valid && wd_scope && wd_channel_ok &&
		    ((CONV_DONE.result < LOW_THRESHOLD) || (CONV_DONE.result > HIGH_THRESHOLD))) begin
			flag_set[`ACSR_FLAG_WATCHDOG] = 1'b1;
		end

		// an injected trigger during a regular group waits for the next channel boundary
		if (INJ_TRIGGER) begin
			next_cur.inj_pending = 1'b1;
		end

		case (cur.seq)
			SEQ_IDLE: begin
				if (cur.inj_pending || INJ_TRIGGER) begin
					next_cur = launch(next_cur, 1'b1, {2'h0, cur.inj_pos});
					next_cur.inj_pending = 1'b0;
					flag_set[`ACSR_FLAG_INJ_START] = 1'b1;
				end else if (REG_TRIGGER) begin
					next_cur = launch(next_cur, 1'b0, cur.reg_pos);
					next_cur.burst_left = cur.ctrl_one[`ACSR_C1_BURST_MSB:`ACSR_C1_BURST_LSB];
					flag_set[`ACSR_FLAG_REG_START] = 1'b1;
				end
			end
			SEQ_REGULAR: begin
				if (CONV_DONE.valid) begin
					if (reg_last) begin
						flag_set[`ACSR_FLAG_CONV_END] = 1'b1;
						next_cur.reg_pos = 4'h0;
						if (ctl(cur.ctrl_one, `ACSR_C1_AUTO_INJ) || next_cur.inj_pending) begin
							next_cur = launch(next_cur, 1'b1, {2'h0, cur.inj_pos});
							next_cur.inj_pending = 1'b0;
							flag_set[`ACSR_FLAG_INJ_START] = 1'b1;
						end else begin
							next_cur.seq = SEQ_IDLE;
						end
					end else begin
						next_cur.reg_pos    = cur.reg_pos + 4'h1;
						next_cur.burst_left = cur.burst_left - 3'h1;
						if (next_cur.inj_pending) begin
							next_cur = launch(next_cur, 1'b1, {2'h0, cur.inj_pos});
							next_cur.inj_pending = 1'b0;
							next_cur.reg_resume  = !burst_end;
							flag_set[`ACSR_FLAG_INJ_START] = 1'b1;
						end else if (burst_end) begin
							next_cur.seq = SEQ_IDLE;
						end else begin
							next_cur = launch(next_cur, 1'b0, cur.reg_pos + 4'h1);
						end
					end
				end
			end
			SEQ_INJECTED: begin
				if (CONV_DONE.valid) begin
					if (inj_last) begin
						flag_set[`ACSR_FLAG_INJ_END]  = 1'b1;
						flag_set[`ACSR_FLAG_CONV_END] = 1'b1;
						next_cur.inj_pos = 2'h0;
						group_done = 1'b1;
					end else begin
						next_cur.inj_pos = cur.inj_pos + 2'h1;
						// split injected groups convert one channel per trigger
						group_done = ctl(cur.ctrl_one, `ACSR_C1_INJ_BURST);
						if (!group_done) begin
							next_cur = launch(next_cur, 1'b1, {2'h0, cur.inj_pos + 2'h1});
						end
					end
					if (group_done) begin
						if (cur.reg_resume) begin
							next_cur = launch(next_cur, 1'b0, cur.reg_pos);
							next_cur.reg_resume = 1'b0;
						end else begin
							next_cur.seq = SEQ_IDLE;
						end
					end
				end
			end
			default: begin
				next_cur.seq = SEQ_IDLE;
			end
		endcase

		// a hardware set in the same cycle as a clear wins
		next_cur.flags = flag_set | (cur.flags & ~flag_clr);
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			cur          <= '0;
			cur.flags    <= `ACSR_STATUS_RESET;
			cur.ctrl_one <= `ACSR_CTRL_ONE_RESET;
			cur.ctrl_two <= `ACSR_CTRL_TWO_RESET;
			cur.seq      <= SEQ_IDLE;
		end else begin
			cur <= next_cur;
		end
	end

endmodule : acsr_regs

// *** acsr_regs_asserts.sv ***
// Purpose: port-level checks of the converter status/control block
// Assumes: one clock REF_CLK, synchronous active-high SYS_RST
// Notes:   flags are internal, so they are judged through bus timing, starts and the irq line
`include "acsr_map.svh"
`timescale 1ns/1ps

module acsr_regs_chk
	import acsr_pkg::*;
(
	input wire logic                    REF_CLK,
	input wire logic                    SYS_RST,
	input wire logic                    S_AXI_AWVALID,
	input wire logic                    S_AXI_AWREADY,
	input wire logic                    S_AXI_WVALID,
	input wire logic                    S_AXI_WREADY,
	input wire logic                    S_AXI_BVALID,
	input wire logic [`ACSR_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic                    S_AXI_ARVALID,
	input wire logic                    S_AXI_ARREADY,
	input wire logic [31:0]             S_AXI_RDATA,
	input wire logic [1:0]              S_AXI_RRESP,
	input wire logic                    S_AXI_RVALID,
	input wire logic                    REG_TRIGGER,
	input wire logic                    INJ_TRIGGER,
	input wire logic                    RESULT_READ,
	input wire acsr_conv_done_type      CONV_DONE,
	input wire logic                    CONV_START,
	input wire logic                    CONV_INJECTED,
	input wire logic                    CONV_BUSY,
	input wire logic                    CONV_IRQ
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SYS_RST);

	property p_rd_latency;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read answer not one cycle later");

	property p_unmapped;
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 12'h008
			|=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

	property p_status_upper;
		S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'h000 |=> S_AXI_RDATA[31:5] == 27'h0;
	endproperty
	a_status_upper: assert property (p_status_upper) else $error("status upper bits set");

	property p_wr_answer;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
			|=> !S_AXI_BVALID ##1 S_AXI_BVALID;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer timing wrong");

	property p_wr_refuse;
		S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
	endproperty
	a_wr_refuse: assert property (p_wr_refuse) else $error("write taken while answer pending");

	property p_reg_start;
		REG_TRIGGER && !INJ_TRIGGER && !CONV_BUSY |=> CONV_START && !CONV_INJECTED;
	endproperty
	a_reg_start: assert property (p_reg_start) else $error("regular group did not start");

	property p_inj_start;
		INJ_TRIGGER && !REG_TRIGGER && !CONV_BUSY |=> CONV_START && CONV_INJECTED;
	endproperty
	a_inj_start: assert property (p_inj_start) else $error("injected group did not start");

	property p_start_pulse;
		CONV_START |=> !CONV_START;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse longer than one cycle");

	// irq may only move after a conversion end, a result read or a register write
	property p_irq_steady;
		S_AXI_AWREADY && S_AXI_WREADY && !CONV_DONE.valid && !RESULT_READ |=> $stable(CONV_IRQ);
	endproperty
	a_irq_steady: assert property (p_irq_steady) else $error("irq moved without cause");
endmodule : acsr_regs_chk

bind acsr_regs acsr_regs_chk chk_u (
	.REF_CLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
	.S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
	.S_AXI_RVALID, .REG_TRIGGER, .INJ_TRIGGER, .RESULT_READ, .CONV_DONE, .CONV_START,
	.CONV_INJECTED, .CONV_BUSY, .CONV_IRQ
);

// *** tb_adc_status_control_regs.sv ***
// Purpose: self-checking bench of the converter status/control block
// Assumes: bench plays bus master and converter core on REF_CLK
// Notes:   conversion ends are only given while busy, one cycle after a start
`timescale 1ns/1ps

module tb_adc_status_control_regs
	import acsr_pkg::*;
;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic [1:0]  r;
	} acsr_row_type;

	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic [11:0]        awaddr = 12'h000;
	logic               awvalid = 1'b0;
	logic [31:0]        wdata = 32'h0;
	logic               wvalid = 1'b0;
	logic               bready = 1'b0;
	logic [11:0]        araddr = 12'h000;
	logic               arvalid = 1'b0;
	logic               rready = 1'b0;
	logic               reg_trigger = 1'b0;
	logic               inj_trigger = 1'b0;
	logic               result_read = 1'b0;
	acsr_conv_done_type conv_done = '0;
	logic [3:0]         reg_seq_last = 4'h1;
	logic [1:0]         inj_seq_last = 2'h0;
	logic               awready, wready, bvalid, arready, rvalid;
	logic               conv_start, conv_injected, conv_busy, conv_irq;
	logic [1:0]         bresp, rresp, r;
	logic [31:0]        rdata, q, control_two;
	logic [3:0]         conv_slot;
	int                 fails = 0;
	int                 samples_checked = 0;
	int                 cycles = 0;
	acsr_row_type       rows [6] = '{
		'{12'h004, 32'hffff_ffff, 32'h00c0_ffff, 2'h0},
		'{12'h008, 32'hffff_ffff, 32'h00fe_f90f, 2'h0},
		'{12'h008, 32'h0000_0000, 32'h0000_0000, 2'h0},
		'{12'h000, 32'h0000_001f, 32'h0000_0000, 2'h0},
		'{12'h00c, 32'h1234_5678, 32'h0000_0000, 2'h2},
		'{12'h004, 32'h0000_0000, 32'h0000_0000, 2'h0}};

	acsr_regs dut_u (
		.REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.REG_TRIGGER(reg_trigger), .INJ_TRIGGER(inj_trigger), .RESULT_READ(result_read),
		.CONV_DONE(conv_done), .REG_SEQ_LAST(reg_seq_last), .INJ_SEQ_LAST(inj_seq_last),
		.LOW_THRESHOLD(12'h064), .HIGH_THRESHOLD(12'h0c8), .CONV_START(conv_start),
		.CONV_INJECTED(conv_injected), .CONV_SLOT(conv_slot), .CONV_BUSY(conv_busy),
		.CONTROL_TWO(control_two), .CONV_IRQ(conv_irq));

	always #12.5 clk = ~clk;

	task automatic results;
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results

	// a hang would otherwise never reach the verdict
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			results();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask : chk_bit

	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 50);
		rs = bresp;
		bready <= 1'b0;
		if (n >= 50) fails++;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 50);
		d = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n >= 50) fails++;
	endtask : rd

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		chk_word(d, exp);
	endtask : rdc

	task automatic trig(input logic inj);
		@(posedge clk);
		if (inj) inj_trigger <= 1'b1;
		else reg_trigger <= 1'b1;
		@(posedge clk);
		inj_trigger <= 1'b0;
		reg_trigger <= 1'b0;
		@(negedge clk);
	endtask : trig

	// called at a falling edge, or at the rising edge that ends a previous convert; plays the converter for one channel
	task automatic convert(input logic inj, input logic [3:0] slot, input logic [11:0] res);
		int n;
		n = 0;
		while (conv_start !== 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		chk_bit(conv_start, 1'b1);
		chk_bit(conv_injected, inj);
		chk_word({28'h0, conv_slot}, {28'h0, slot});
		@(posedge clk);
		conv_done <= '{1'b1, inj, {1'b0, slot}, res};
		@(posedge clk);
		conv_done <= '0;
	endtask : convert

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(12'h000, 32'h0);
		rdc(12'h004, 32'h0);
		rdc(12'h008, 32'h0);
		for (int i = 0; i < 6; i++) begin
			wr(rows[i].a, rows[i].d, r);
			chk_word({30'h0, r}, {30'h0, rows[i].r});
			rd(rows[i].a, q, r);
			chk_word(q, rows[i].q);
			if (rows[i].a == 12'h008) chk_word(control_two, rows[i].q);
			chk_word({30'h0, r}, {30'h0, rows[i].r});
		end
		wr(12'h004, 32'h0000_0120, r);
		trig(1'b0);
		convert(1'b0, 4'h0, 12'h010);
		@(negedge clk);
		chk_bit(conv_irq, 1'b0);
		convert(1'b0, 4'h1, 12'h010);
		@(negedge clk);
		chk_bit(conv_irq, 1'b1);
		rdc(12'h000, 32'h12);
		@(posedge clk);
		result_read <= 1'b1;
		@(posedge clk);
		result_read <= 1'b0;
		rdc(12'h000, 32'h10);
		chk_bit(conv_irq, 1'b0);
		wr(12'h000, 32'h0, r);
		rdc(12'h000, 32'h0);
		wr(12'h004, 32'h0040_00c0, r);
		trig(1'b1);
		convert(1'b1, 4'h0, 12'h12c);
		@(negedge clk);
		chk_bit(conv_irq, 1'b1);
		rdc(12'h000, 32'h0f);
		wr(12'h000, 32'h1, r);
		rdc(12'h000, 32'h01);
		chk_bit(conv_irq, 1'b1);
		wr(12'h004, 32'h0040_0080, r);
		chk_bit(conv_irq, 1'b0);
		wr(12'h000, 32'h0, r);
		// two-channel bursts over a four-slot list, watchdog scope off then on
		wr(12'h004, 32'h0000_2800, r);
		reg_seq_last <= 4'h3;
		trig(1'b0);
		convert(1'b0, 4'h0, 12'h12c);
		convert(1'b0, 4'h1, 12'h12c);
		@(negedge clk);
		chk_bit(conv_busy, 1'b0);
		rdc(12'h000, 32'h10);
		wr(12'h004, 32'h0080_2800, r);
		trig(1'b0);
		convert(1'b0, 4'h2, 12'h12c);
		convert(1'b0, 4'h3, 12'h12c);
		rdc(12'h000, 32'h13);
		wr(12'h000, 32'h0, r);
		wr(12'h004, 32'h0000_0400, r);
		reg_seq_last <= 4'h0;
		trig(1'b0);
		convert(1'b0, 4'h0, 12'h010);
		convert(1'b1, 4'h0, 12'h010);
		rdc(12'h000, 32'h1e);
		wr(12'h000, 32'h0, r);
		// single-channel watchdog: channel 1 guarded first, then channel 0
		wr(12'h004, 32'h0080_0201, r);
		trig(1'b0);
		convert(1'b0, 4'h0, 12'h12c);
		rdc(12'h000, 32'h12);
		wr(12'h000, 32'h0, r);
		wr(12'h004, 32'h0080_0200, r);
		trig(1'b0);
		convert(1'b0, 4'h0, 12'h12c);
		rdc(12'h000, 32'h13);
		wr(12'h000, 32'h0, r);
		// split injected group of two slots, one slot per trigger
		wr(12'h004, 32'h0000_1000, r);
		inj_seq_last <= 2'h1;
		trig(1'b1);
		convert(1'b1, 4'h0, 12'h010);
		rdc(12'h000, 32'h08);
		trig(1'b1);
		convert(1'b1, 4'h1, 12'h010);
		rdc(12'h000, 32'h0e);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(12'h000, 32'h0);
		rdc(12'h004, 32'h0);
		chk_bit(conv_irq, 1'b0);
		results();
	end
endmodule : tb_adc_status_control_regs
